// [src/tamper_detect_control.sv]
`timescale 1ns/1ps
// Function
// - Enabled tamper interrupt asserts interrupt output on tamper event.
// - On battery the interrupt also needs backup alarm enable.
// - Switch mode 1 is normally open, 0 normally closed.
// - Polarity 1 means tamper drives input high, 0 low.
// - Normally closed: sample select picks 1Hz sampling or continuous.
// - Normally open ignores sample select and monitors continuously.
// - Sampling only works while the oscillator runs.
// - Pull strength 1 strong, 0 weak; ignored in normally open.
// - Internal wipe plus enable clears all user RAM on tamper.
// - User RAM stays deselected after wipe until enable cleared.
// - External wipe plus enable starts SRAM clear and asserts reset.
// - Tamper reset behaves like any other reset source.
// - Wipe pulse output low normally, high on external wipe tamper.
// - External wipe on battery disconnects backup supply from battery.
// - Two-bit width field sets how long wipe pulse stays high.
// - Second tamper-high on channel b during pulse is not detected if channel b has external wipe enabled.
// - Tamper sets read-only flag; cleared only by enable going low.
// - Width codes 0..3 give 1, 4, 8, 16 seconds.
// - Interrupt cleared by flags read, both interrupt enables low, or reset output.
// - Stopped oscillator makes sampling fall back to continuous.
module tamper_detect_control (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // Channel a configuration
    input  wire logic tamper_enable_a_i,
    input  wire logic tamper_irq_enable_a_i,
    input  wire logic switch_mode_a_i,
    input  wire logic trigger_polarity_a_i,
    input  wire logic sample_select_a_i,
    input  wire logic pull_strength_a_i,
    input  wire logic user_ram_wipe_a_i,
    input  wire logic ext_sram_wipe_a_i,
    // Channel b configuration
    input  wire logic tamper_enable_b_i,
    input  wire logic tamper_irq_enable_b_i,
    input  wire logic switch_mode_b_i,
    input  wire logic trigger_polarity_b_i,
    input  wire logic sample_select_b_i,
    input  wire logic pull_strength_b_i,
    input  wire logic user_ram_wipe_b_i,
    input  wire logic ext_sram_wipe_b_i,
    // Shared configuration and system status
    input  wire logic       backup_alarm_enable_i,
    input  wire logic [1:0] wipe_width_i,
    input  wire logic       on_battery_i,
    input  wire logic       osc_running_i,
    input  wire logic       flags_read_i,
    input  wire logic       other_reset_i,
    // Tamper pins
    input  wire logic tamper_input_a_i,
    input  wire logic tamper_input_b_i,
    // Status and controls out
    output logic tamper_flag_a_o,
    output logic tamper_flag_b_o,
    output logic irq_o,
    output logic system_reset_o,
    output logic wipe_pulse_output_o,
    output logic backup_supply_off_o,
    output logic user_ram_clear_o,
    output logic user_ram_deselect_o,
    output logic pull_on_a_o,
    output logic pull_strong_a_o,
    output logic pull_on_b_o,
    output logic pull_strong_b_o,
    output logic sampling_active_o
);

    // Registers
    logic        irq_q;
    logic        irq_d;
    logic        pulse_q;
    logic        pulse_d;
    logic [31:0] pulse_cnt_q;
    logic [31:0] pulse_cnt_d;
    logic [4:0]  secs_q;
    logic [4:0]  secs_d;
    logic        supply_off_q;
    logic        supply_off_d;
    logic        clear_q;
    logic        desel_a_q;
    logic        desel_b_q;
    logic [31:0] tick_q;
    logic [31:0] tick_d;
    logic        sys_reset_q;

    // Wires
    logic       event_a;
    logic       event_b;
    logic       window;
    logic       irq_set;
    logic       irq_clear;
    logic       ext_event;
    logic       int_event;
    logic [4:0] width_secs;
    logic       sec_tick;
    logic       pulse_done;

    // 1 Hz sampling window from a free-running second counter
    assign window   = (tick_q < 32'(tamper_pkg::SAMPLE_WIN_CYC));
    assign sec_tick = (tick_q == 32'(tamper_pkg::SEC_CYCLES - 1));
    assign tick_d   = sec_tick ? 32'h0 : tick_q + 32'h1;
    assign sampling_active_o = !window;

    tamper_channel chan_a (
        .clk_i              (clk_i),
        .reset_i            (reset_i),
        .tamper_enable_i    (tamper_enable_a_i),
        .switch_mode_i      (switch_mode_a_i),
        .trigger_polarity_i (trigger_polarity_a_i),
        .sample_select_i    (sample_select_a_i),
        .sample_window_i    (window),
        .osc_running_i      (osc_running_i),
        .block_high_i       (1'b0),
        .tamper_input_i     (tamper_input_a_i),
        .event_o            (event_a),
        .tamper_flag_o      (tamper_flag_a_o)
    );

    tamper_channel chan_b (
        .clk_i              (clk_i),
        .reset_i            (reset_i),
        .tamper_enable_i    (tamper_enable_b_i),
        .switch_mode_i      (switch_mode_b_i),
        .trigger_polarity_i (trigger_polarity_b_i),
        .sample_select_i    (sample_select_b_i),
        .sample_window_i    (window),
        .osc_running_i      (osc_running_i),
        .block_high_i       (pulse_q && ext_sram_wipe_b_i),
        .tamper_input_i     (tamper_input_b_i),
        .event_o            (event_b),
        .tamper_flag_o      (tamper_flag_b_o)
    );

    // Pull resistor control, normally closed only
    assign pull_on_a_o     = tamper_enable_a_i && !switch_mode_a_i;
    assign pull_strong_a_o = pull_on_a_o && pull_strength_a_i;
    assign pull_on_b_o     = tamper_enable_b_i && !switch_mode_b_i;
    assign pull_strong_b_o = pull_on_b_o && pull_strength_b_i;

    // Interrupt set and clear terms; set wins over clear
    assign irq_set = ((event_a && tamper_irq_enable_a_i)
                   || (event_b && tamper_irq_enable_b_i))
                   && (!on_battery_i || backup_alarm_enable_i);
    assign irq_clear = flags_read_i
                     || (!tamper_irq_enable_a_i && !tamper_irq_enable_b_i)
                     || system_reset_o;
    assign irq_d = irq_set || (irq_q && !irq_clear);

    // Wipe events
    assign ext_event = (event_a && ext_sram_wipe_a_i)
                     || (event_b && ext_sram_wipe_b_i);
    assign int_event = (event_a && user_ram_wipe_a_i)
                     || (event_b && user_ram_wipe_b_i);

    // Pulse width in seconds from the width field
    assign width_secs =
        (wipe_width_i == tamper_pkg::WIDTH_1S)  ? 5'(tamper_pkg::PULSE_S_0) :
        (wipe_width_i == tamper_pkg::WIDTH_4S)  ? 5'(tamper_pkg::PULSE_S_1) :
        (wipe_width_i == tamper_pkg::WIDTH_8S)  ? 5'(tamper_pkg::PULSE_S_2) :
                                                  5'(tamper_pkg::PULSE_S_3);

    // Pulse timing: count whole seconds of clock cycles
    assign pulse_done = pulse_q
                     && (pulse_cnt_q == 32'(tamper_pkg::SEC_CYCLES - 1))
                     && (secs_q == 5'h1);
    assign pulse_d = ext_event || (pulse_q && !pulse_done);
    // A new wipe event in the last cycle restarts the count, no wrap
    assign pulse_cnt_d = (ext_event && (!pulse_q || pulse_done)) ? 32'h0 :
        (pulse_cnt_q == 32'(tamper_pkg::SEC_CYCLES - 1)) ? 32'h0 :
        pulse_cnt_q + 32'h1;
    assign secs_d = (ext_event && (!pulse_q || pulse_done)) ? width_secs :
        (pulse_q && pulse_cnt_q == 32'(tamper_pkg::SEC_CYCLES - 1))
            ? secs_q - 5'h1 : secs_q;
    // Battery disconnect latched until back on main supply
    assign supply_off_d = (ext_event && on_battery_i)
                        || (supply_off_q && on_battery_i);

    // Sampling counter
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tick_q <= 32'h0;
        end else begin
            tick_q <= tick_d;
        end
    end

    // Interrupt
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Wipe pulse and supply disconnect
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pulse_q      <= tamper_pkg::PULSE_RESET;
            pulse_cnt_q  <= 32'h0;
            secs_q       <= 5'h0;
            supply_off_q <= 1'b0;
        end else begin
            pulse_q      <= pulse_d;
            pulse_cnt_q  <= pulse_cnt_d;
            secs_q       <= secs_d;
            supply_off_q <= supply_off_d;
        end
    end

    // User RAM clear strobe and deselect per channel
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            clear_q   <= 1'b0;
            desel_a_q <= 1'b0;
            desel_b_q <= 1'b0;
        end else begin
            clear_q   <= int_event;
            desel_a_q <= tamper_enable_a_i
                && (desel_a_q || (event_a && user_ram_wipe_a_i));
            desel_b_q <= tamper_enable_b_i
                && (desel_b_q || (event_b && user_ram_wipe_b_i));
        end
    end

    // System reset: tamper merges with other reset causes
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sys_reset_q <= 1'b0;
        end else begin
            sys_reset_q <= pulse_d || other_reset_i;
        end
    end

    // Outputs
    assign irq_o               = irq_q;
    assign system_reset_o      = sys_reset_q;
    assign wipe_pulse_output_o = pulse_q;
    assign backup_supply_off_o = supply_off_q;
    assign user_ram_clear_o    = clear_q;
    assign user_ram_deselect_o = desel_a_q || desel_b_q;

endmodule // tamper_detect_control

// [include/tamper_pkg.sv]
package tamper_pkg;

    // Clock rate and derived counts
    localparam longint CLK_HZ          = 10000000;
    localparam int     SECOND_MS       = 1000;
    localparam int     SAMPLE_WIN_MS   = 1;
    localparam int     SAMPLE_PERIOD_S = 1;
    localparam int     PULSE_S_0       = 1;
    localparam int     PULSE_S_1       = 4;
    localparam int     PULSE_S_2       = 8;
    localparam int     PULSE_S_3       = 16;
    localparam int     SEC_CYCLES      = int'(CLK_HZ);
    localparam int     SAMPLE_WIN_CYC  =
        int'((CLK_HZ * SAMPLE_WIN_MS) / SECOND_MS);

    // Wipe pulse width codes
    localparam logic [1:0] WIDTH_1S  = 2'h0;
    localparam logic [1:0] WIDTH_4S  = 2'h1;
    localparam logic [1:0] WIDTH_8S  = 2'h2;
    localparam logic [1:0] WIDTH_16S = 2'h3;

    // Reset values
    localparam logic FLAG_RESET  = 1'h0;
    localparam logic PULSE_RESET = 1'h0;

endpackage

// [src/tamper_channel.sv]
`timescale 1ns/1ps
// One tamper channel: input qualification and sticky flag
module tamper_channel (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // Configuration
    input  wire logic tamper_enable_i,
    input  wire logic switch_mode_i,
    input  wire logic trigger_polarity_i,
    input  wire logic sample_select_i,
    input  wire logic sample_window_i,
    input  wire logic osc_running_i,
    input  wire logic block_high_i,
    // Pin and results
    input  wire logic tamper_input_i,
    output logic      event_o,
    output logic      tamper_flag_o
);

    logic flag_q;
    logic flag_d;
    logic sampling;
    logic active_level;
    logic look;

    // Sampling only for normally closed with oscillator running
    assign sampling = !switch_mode_i && sample_select_i
                      && osc_running_i;
    assign look = !sampling || sample_window_i;
    // Tamper level per polarity; mode selects wiring only
    assign active_level = (tamper_input_i == trigger_polarity_i);
    assign event_o = tamper_enable_i && look && active_level
                     && !(block_high_i && trigger_polarity_i)
                     && !flag_q;
    // Flag sets on event, clears only when enable is low
    assign flag_d = !tamper_enable_i ? 1'b0 : (flag_q | event_o);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flag_q <= tamper_pkg::FLAG_RESET;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign tamper_flag_o = flag_q;

endmodule // tamper_channel

// [dv/tamper_switch_model.sv]
`timescale 1ns/1ps
// External tamper switch; the pull holds the pin at its idle level
module tamper_switch_model (
    // Switch state and wiring option
    input  wire logic switch_closed_i,
    input  wire logic switch_mode_i,
    input  wire logic trigger_polarity_i,
    // Pin level seen by the device
    output logic      pin_o
);
    // Open mode trips on closing, closed mode on opening
    wire logic tripped = switch_mode_i ? switch_closed_i
                                       : !switch_closed_i;
    // A tripped pin sits at the polarity level, an idle one at the other
    assign pin_o = tripped ? trigger_polarity_i : !trigger_polarity_i;
endmodule // tamper_switch_model

// [dv/tamper_detect_control_asserts.sv]
`timescale 1ns/1ps
// Port checks on the tamper controller
module tamper_detect_checker (
    // Clock, reset and inputs
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic tamper_enable_a_i,
    input wire logic tamper_enable_b_i,
    input wire logic tamper_irq_enable_a_i,
    input wire logic switch_mode_a_i,
    input wire logic trigger_polarity_a_i,
    input wire logic sample_select_a_i,
    input wire logic user_ram_wipe_a_i,
    input wire logic on_battery_i,
    input wire logic backup_alarm_enable_i,
    input wire logic osc_running_i,
    input wire logic flags_read_i,
    input wire logic tamper_input_a_i,
    // Outputs
    input wire logic tamper_flag_a_o,
    input wire logic tamper_flag_b_o,
    input wire logic irq_o,
    input wire logic system_reset_o,
    input wire logic wipe_pulse_output_o,
    input wire logic backup_supply_off_o,
    input wire logic user_ram_clear_o,
    input wire logic user_ram_deselect_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // Channel a at the tamper level with no sampling gap
    wire logic hit_a = tamper_enable_a_i
        && (tamper_input_a_i == trigger_polarity_a_i)
        && (switch_mode_a_i || !sample_select_a_i || !osc_running_i);
    // Interrupt allowed off battery, or on it with the alarm enable
    wire logic irq_ok = !on_battery_i || backup_alarm_enable_i;
    // Neither channel can take a fresh event
    wire logic quiet = (tamper_flag_a_o || !tamper_enable_a_i)
        && (tamper_flag_b_o || !tamper_enable_b_i);
    // One-cycle wipe strobe, then the RAM stays deselected
    sequence ram_wipe_s;
        user_ram_clear_o ##1 (!user_ram_clear_o && user_ram_deselect_o);
    endsequence
    flag_sets_a: assert property (hit_a |=> tamper_flag_a_o)
        else $error("flag a not set");
    flag_holds_a: assert property (
        tamper_flag_a_o && tamper_enable_a_i |=> tamper_flag_a_o)
        else $error("flag a dropped");
    flag_clears_b: assert property (
        !tamper_enable_b_i |=> !tamper_flag_b_o)
        else $error("flag b kept");
    irq_follows_a: assert property ($rose(tamper_flag_a_o)
        && $past(tamper_irq_enable_a_i && irq_ok) |-> irq_o)
        else $error("irq missing");
    irq_battery_a: assert property ($rose(irq_o) |-> $past(irq_ok))
        else $error("irq on battery");
    irq_read_a: assert property (
        irq_o && flags_read_i && quiet |=> !irq_o)
        else $error("irq not cleared");
    ram_wipe_a: assert property (
        $rose(tamper_flag_a_o) && $past(user_ram_wipe_a_i) |-> ram_wipe_s)
        else $error("ram wipe wrong");
    wipe_reset_a: assert property (
        $rose(wipe_pulse_output_o) |-> system_reset_o)
        else $error("no reset with wipe");
    wipe_hold_a: assert property (
        $rose(wipe_pulse_output_o) |=> wipe_pulse_output_o [*8])
        else $error("wipe pulse short");
    supply_cut_a: assert property (
        $rose(wipe_pulse_output_o) && $past(on_battery_i)
        |-> ##[0:1] backup_supply_off_o)
        else $error("supply kept");
endmodule // tamper_detect_checker

// [dv/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    mismatches++; $display("unexpected %s exp %0h got %0h", nm, ex, got); \
    end end
// Bench driving the tamper controller through two switch models
module tb_top;
    // Inputs, switch states and outputs
    logic clk_i, reset_i, closed_a, closed_b;
    logic tamper_input_a_i, tamper_input_b_i;
    logic tamper_enable_a_i, tamper_irq_enable_a_i, switch_mode_a_i;
    logic trigger_polarity_a_i, sample_select_a_i, pull_strength_a_i;
    logic user_ram_wipe_a_i, ext_sram_wipe_a_i, tamper_enable_b_i;
    logic tamper_irq_enable_b_i, switch_mode_b_i, trigger_polarity_b_i;
    logic sample_select_b_i, pull_strength_b_i, user_ram_wipe_b_i;
    logic ext_sram_wipe_b_i, backup_alarm_enable_i, on_battery_i;
    logic osc_running_i, flags_read_i, other_reset_i;
    logic [1:0] wipe_width_i;
    logic tamper_flag_a_o, tamper_flag_b_o, irq_o, system_reset_o;
    logic wipe_pulse_output_o, backup_supply_off_o, user_ram_clear_o;
    logic user_ram_deselect_o, pull_on_a_o, pull_strong_a_o, pull_on_b_o;
    logic pull_strong_b_o, sampling_active_o;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    tamper_detect_control dut_u (.*);
    tamper_switch_model sw_a_u (
        .switch_closed_i    (closed_a),
        .switch_mode_i      (switch_mode_a_i),
        .trigger_polarity_i (trigger_polarity_a_i),
        .pin_o              (tamper_input_a_i)
    );
    tamper_switch_model sw_b_u (
        .switch_closed_i    (closed_b),
        .switch_mode_i      (switch_mode_b_i),
        .trigger_polarity_i (trigger_polarity_b_i),
        .pin_o              (tamper_input_b_i)
    );
    // Step to just after the next n rising edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Hang limit
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    // Main sequence
    initial begin
        {closed_a, closed_b, tamper_enable_a_i, tamper_irq_enable_a_i,
         switch_mode_a_i, trigger_polarity_a_i, sample_select_a_i,
         pull_strength_a_i, user_ram_wipe_a_i, ext_sram_wipe_a_i,
         tamper_enable_b_i, tamper_irq_enable_b_i, switch_mode_b_i,
         trigger_polarity_b_i, sample_select_b_i, pull_strength_b_i,
         user_ram_wipe_b_i, ext_sram_wipe_b_i, backup_alarm_enable_i,
         on_battery_i, flags_read_i, other_reset_i, wipe_width_i} = '0;
        reset_i = 1'b1;
        osc_running_i = 1'b1;
        tick(16);
        reset_i = 1'b0;
        tick(10);
        `CHK("sample window", 1'h0, sampling_active_o)
        tick(10000);
        `CHK("pulse idle", 1'h0, wipe_pulse_output_o)
        `CHK("sample gap", 1'h1, sampling_active_o)
        // Open switch, high tamper, sampling asked for but ignored
        {switch_mode_a_i, trigger_polarity_a_i, sample_select_a_i} = 3'h7;
        {tamper_enable_a_i, tamper_irq_enable_a_i, pull_strength_a_i} = 3'h7;
        tick(3);
        `CHK("flag a idle", 1'h0, tamper_flag_a_o)
        `CHK("pull a open", 1'h0, pull_on_a_o)
        closed_a = 1'b1;
        tick(2);
        `CHK("flag a", 1'h1, tamper_flag_a_o)
        `CHK("irq", 1'h1, irq_o)
        flags_read_i = 1'b1;
        tick(1);
        flags_read_i = 1'b0;
        tick(1);
        `CHK("irq read", 1'h0, irq_o)
        `CHK("flag a kept", 1'h1, tamper_flag_a_o)
        tamper_enable_a_i = 1'b0;
        tick(2);
        `CHK("flag a off", 1'h0, tamper_flag_a_o)
        // Every mode and polarity: sampled gap, then oscillator stopped
        sample_select_b_i = 1'b1;
        for (int m = 0; m < 4; m++) begin
            {switch_mode_b_i, trigger_polarity_b_i} = 2'(m);
            closed_b = !switch_mode_b_i;
            osc_running_i = 1'b1;
            tick(1);
            tamper_enable_b_i = 1'b1;
            tick(2);
            closed_b = switch_mode_b_i;
            tick(3);
            `CHK("flag b sampled", switch_mode_b_i, tamper_flag_b_o)
            `CHK("pull b on", !switch_mode_b_i, pull_on_b_o)
            `CHK("pull b weak", 1'h0, pull_strong_b_o)
            osc_running_i = 1'b0;
            tick(3);
            `CHK("flag b", 1'h1, tamper_flag_b_o)
            tamper_enable_b_i = 1'b0;
            tick(2);
        end
        // Battery: interrupt needs the alarm enable
        {switch_mode_a_i, trigger_polarity_a_i} = 2'h0;
        {sample_select_a_i, closed_a} = 2'h1;
        {on_battery_i, tamper_enable_a_i} = 2'h3;
        tick(2);
        closed_a = 1'b0;
        tick(2);
        `CHK("flag a batt", 1'h1, tamper_flag_a_o)
        `CHK("irq batt", 1'h0, irq_o)
        `CHK("pull a strong", 1'h1, pull_strong_a_o)
        {tamper_enable_a_i, closed_a, backup_alarm_enable_i} = 3'h3;
        tick(2);
        tamper_enable_a_i = 1'b1;
        tick(2);
        closed_a = 1'b0;
        tick(2);
        `CHK("irq alarm", 1'h1, irq_o)
        tamper_irq_enable_a_i = 1'b0;
        tick(2);
        `CHK("irq off", 1'h0, irq_o)
        // Internal RAM wipe
        {tamper_enable_a_i, closed_a, user_ram_wipe_a_i} = 3'h3;
        tick(2);
        tamper_enable_a_i = 1'b1;
        tick(2);
        closed_a = 1'b0;
        tick(1);
        `CHK("ram clear", 1'h1, user_ram_clear_o)
        tick(6);
        `CHK("ram clear end", 1'h0, user_ram_clear_o)
        `CHK("deselect", 1'h1, user_ram_deselect_o)
        tamper_enable_a_i = 1'b0;
        tick(2);
        `CHK("deselect off", 1'h0, user_ram_deselect_o)
        // External wipe on channel b while on battery
        {switch_mode_b_i, trigger_polarity_b_i} = 2'h1;
        {sample_select_b_i, closed_b} = 2'h1;
        {ext_sram_wipe_b_i, tamper_irq_enable_b_i} = 2'h3;
        wipe_width_i = tamper_pkg::WIDTH_4S;
        tick(1);
        tamper_enable_b_i = 1'b1;
        tick(2);
        closed_b = 1'b0;
        tick(2);
        `CHK("wipe pulse", 1'h1, wipe_pulse_output_o)
        `CHK("sys reset", 1'h1, system_reset_o)
        tick(1);
        `CHK("irq by reset", 1'h0, irq_o)
        `CHK("supply off", 1'h1, backup_supply_off_o)
        // Re-arm channel b while the pulse runs: high tamper is ignored
        tamper_enable_b_i = 1'b0;
        tick(2);
        tamper_enable_b_i = 1'b1;
        tick(3);
        `CHK("flag b blocked", 1'h0, tamper_flag_b_o)
        tick(2000);
        `CHK("pulse held", 1'h1, wipe_pulse_output_o)
        reset_i = 1'b1;
        tick(2);
        {reset_i, tamper_enable_b_i, tamper_enable_a_i} = 3'h0;
        tick(2);
        `CHK("pulse cut", 1'h0, wipe_pulse_output_o)
        other_reset_i = 1'b1;
        tick(3);
        `CHK("other reset", 1'h1, system_reset_o)
        results();
    end
endmodule // tb_top
bind tamper_detect_control tamper_detect_checker chk_u (.*);
